// file: bridge_tail_defines.svh
`ifndef BRIDGE_TAIL_DEFINES_SVH
`define BRIDGE_TAIL_DEFINES_SVH

// byte offsets inside the configuration header
`define OFS_CAPABILITY_LIST_HEAD     8'h34
`define OFS_ROM_WINDOW_BASE          8'h38
`define OFS_IRQ_ROUTING_NOTE         8'h3C
`define OFS_IRQ_TERMINAL_CODE        8'h3D
`define OFS_BRIDGE_SECONDARY_CONTROL 8'h3E

// dword indices used by the decoder (byte offset divided by four)
`define DW_CAPABILITY_LIST_HEAD      6'h0D
`define DW_ROM_WINDOW_BASE           6'h0E
`define DW_IRQ_DWORD                 6'h0F

// reset and fixed read values
`define RST_CAPABILITY_LIST_HEAD     8'hDC
`define RST_ROM_WINDOW_BASE          32'h00000000
`define RST_IRQ_ROUTING_NOTE         8'hFF
`define RST_IRQ_TERMINAL_CODE        8'h00
`define RST_BRIDGE_SECONDARY_CONTROL 16'h0000

// bridge secondary control field positions
`define BSC_RESERVED_HI              15
`define BSC_RESERVED_LO              12
`define BSC_DISCARD_SERR_EN          11
`define BSC_DISCARD_STATUS           10
`define BSC_SEC_SHORT_TIMER          9
`define BSC_PRI_SHORT_TIMER          8
`define BSC_FAST_B2B                 7

// discard timer lengths in clock cycles
`define DISCARD_LONG_CYCLES          32768
`define DISCARD_SHORT_CYCLES         1024

`endif

// file: bridge_tail_pkg.sv
package bridge_tail_pkg;

    // one configuration access from the primary bus
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  addr;
        logic [3:0]  byte_en;
        logic [31:0] wdata;
    } cfg_req_type;

    // registered answer to one configuration access
    typedef struct packed {
        logic        ack;
        logic        hit;
        logic [31:0] rdata;
    } cfg_rsp_type;

    // discard events toward the delayed-transaction queue
    typedef struct packed {
        logic primary;
        logic secondary;
    } discard_type;

endpackage : bridge_tail_pkg

// file: discard_timer.sv
`include "bridge_tail_defines.svh"

module discard_timer #(
    parameter int LONG_CYCLES  = `DISCARD_LONG_CYCLES,
    parameter int SHORT_CYCLES = `DISCARD_SHORT_CYCLES,
    parameter int CNT_W        = $clog2(LONG_CYCLES)
) (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic clk_en,
    input  wire logic pending,
    input  wire logic repeated,
    input  wire logic short_sel,
    output logic      expired
);

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] limit;
    logic             hit_end;
    logic             expired_q;
    logic             expired_d;

    // last count before the discard, picked by the length select
    assign limit     = short_sel ? CNT_W'(SHORT_CYCLES - 1) : CNT_W'(LONG_CYCLES - 1);
    assign hit_end   = pending && !repeated && (cnt_q == limit);
    assign cnt_d     = (!pending || repeated || hit_end) ? '0 : cnt_q + 1'b1;
    assign expired_d = hit_end;
    assign expired   = expired_q;

    // wait counter, restarted whenever the master comes back
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cnt_q     <= '0;
            expired_q <= 1'b0;
        end else if (clk_en) begin
            cnt_q     <= cnt_d;
            expired_q <= expired_d;
        end
    end

endmodule : discard_timer

// file: bridge_config_header_tail.sv
`include "bridge_tail_defines.svh"

module bridge_config_header_tail
    import bridge_tail_pkg::*;
#(
    parameter int LONG_CYCLES  = `DISCARD_LONG_CYCLES,
    parameter int SHORT_CYCLES = `DISCARD_SHORT_CYCLES
) (
    input  wire logic  core_clk,
    input  wire logic  reset,
    input  wire logic  clk_en,
    input  cfg_req_type cfg_req,
    output cfg_rsp_type cfg_rsp,
    input  wire logic  pri_delayed_pending,
    input  wire logic  pri_delayed_repeat,
    input  wire logic  sec_delayed_pending,
    input  wire logic  sec_delayed_repeat,
    output discard_type discard,
    output logic       discard_serr,
    output logic       discard_serr_en,
    output logic       pri_short_timer,
    output logic       sec_short_timer
);

    // stored fields
    logic [7:0]  routing_note_q;
    logic [7:0]  routing_note_d;
    logic        serr_en_q;
    logic        serr_en_d;
    logic        status_q;
    logic        status_d;
    logic        sec_short_q;
    logic        sec_short_d;
    logic        pri_short_q;
    logic        pri_short_d;

    // answer registers
    cfg_rsp_type rsp_q;
    cfg_rsp_type rsp_d;

    // discard event registers
    discard_type discard_q;
    discard_type discard_d;
    logic        serr_q;
    logic        serr_d;

    // decode wires
    logic [5:0]  dword;
    logic        sel_cap;
    logic        sel_rom;
    logic        sel_irq;
    logic        any_sel;
    logic        wr_cycle;
    logic        wr_note;
    logic        wr_ctrl_hi;
    logic [7:0]  ctrl_hi_byte;
    logic        clear_status;

    // timer results
    logic        pri_expired;
    logic        sec_expired;
    logic        any_expired;

    // read assembly
    logic [15:0] ctrl_word;
    logic [31:0] irq_dword;
    logic [31:0] read_value;

    // decode of the dword being addressed
    assign dword   = cfg_req.addr[7:2];
    assign sel_cap = (dword == `DW_CAPABILITY_LIST_HEAD);
    assign sel_rom = (dword == `DW_ROM_WINDOW_BASE);
    assign sel_irq = (dword == `DW_IRQ_DWORD);
    assign any_sel = sel_cap || sel_rom || sel_irq;

    // write strobes by byte lane
    assign wr_cycle     = cfg_req.valid && cfg_req.write;
    assign wr_note      = wr_cycle && sel_irq && cfg_req.byte_en[0];
    assign wr_ctrl_hi   = wr_cycle && sel_irq && cfg_req.byte_en[3];
    assign ctrl_hi_byte = cfg_req.wdata[31:24];

    // one written to the status position clears it
    assign clear_status = wr_ctrl_hi && ctrl_hi_byte[`BSC_DISCARD_STATUS - 8];

    // routing note takes any byte software writes
    assign routing_note_d = wr_note ? cfg_req.wdata[7:0] : routing_note_q;

    // read/write control bits in the upper byte
    assign serr_en_d   = wr_ctrl_hi ? ctrl_hi_byte[`BSC_DISCARD_SERR_EN - 8]
                                    : serr_en_q;
    assign sec_short_d = wr_ctrl_hi ? ctrl_hi_byte[`BSC_SEC_SHORT_TIMER - 8]
                                    : sec_short_q;
    assign pri_short_d = wr_ctrl_hi ? ctrl_hi_byte[`BSC_PRI_SHORT_TIMER - 8]
                                    : pri_short_q;

    // status: a new expiry wins over a clear in the same cycle
    assign any_expired = pri_expired || sec_expired;
    assign status_d    = any_expired ? 1'b1
                       : clear_status ? 1'b0
                       : status_q;

    // secondary control as software reads it
    always_comb begin
        ctrl_word = `RST_BRIDGE_SECONDARY_CONTROL;
        ctrl_word[`BSC_RESERVED_HI:`BSC_RESERVED_LO] = 4'h0;
        ctrl_word[`BSC_DISCARD_SERR_EN] = serr_en_q;
        ctrl_word[`BSC_DISCARD_STATUS]  = status_q;
        ctrl_word[`BSC_SEC_SHORT_TIMER] = sec_short_q;
        ctrl_word[`BSC_PRI_SHORT_TIMER] = pri_short_q;
        ctrl_word[`BSC_FAST_B2B]        = 1'b0;
    end

    // dword holding note, terminal code and control
    assign irq_dword = {ctrl_word, `RST_IRQ_TERMINAL_CODE, routing_note_q};

    // read mux, unmapped dwords in this range return zero
    assign read_value = sel_cap ? {24'h000000, `RST_CAPABILITY_LIST_HEAD}
                      : sel_rom ? `RST_ROM_WINDOW_BASE
                      : sel_irq ? irq_dword
                      : 32'h00000000;

    // answer built for the next cycle, reads and writes alike
    always_comb begin
        rsp_d       = '0;
        rsp_d.ack   = cfg_req.valid;
        rsp_d.hit   = cfg_req.valid && any_sel;
        rsp_d.rdata = (cfg_req.valid && !cfg_req.write) ? read_value : 32'h00000000;
    end

    // discard pulses toward the queue and SERR request
    always_comb begin
        discard_d           = '0;
        discard_d.primary   = pri_expired;
        discard_d.secondary = sec_expired;
        serr_d              = pri_expired && serr_en_q;
    end

    // primary side discard timer
    discard_timer #(
        .LONG_CYCLES  (LONG_CYCLES),
        .SHORT_CYCLES (SHORT_CYCLES)
    ) u_pri_timer (
        .core_clk  (core_clk),
        .reset     (reset),
        .clk_en    (clk_en),
        .pending   (pri_delayed_pending),
        .repeated  (pri_delayed_repeat),
        .short_sel (pri_short_q),
        .expired   (pri_expired)
    );

    // secondary side discard timer
    discard_timer #(
        .LONG_CYCLES  (LONG_CYCLES),
        .SHORT_CYCLES (SHORT_CYCLES)
    ) u_sec_timer (
        .core_clk  (core_clk),
        .reset     (reset),
        .clk_en    (clk_en),
        .pending   (sec_delayed_pending),
        .repeated  (sec_delayed_repeat),
        .short_sel (sec_short_q),
        .expired   (sec_expired)
    );

    // software visible storage
    always_ff @(posedge core_clk) begin
        if (reset) begin
            routing_note_q <= `RST_IRQ_ROUTING_NOTE;
            serr_en_q      <= 1'b0;
            status_q       <= 1'b0;
            sec_short_q    <= 1'b0;
            pri_short_q    <= 1'b0;
        end else if (clk_en) begin
            routing_note_q <= routing_note_d;
            serr_en_q      <= serr_en_d;
            status_q       <= status_d;
            sec_short_q    <= sec_short_d;
            pri_short_q    <= pri_short_d;
        end
    end

    // answer and event registers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rsp_q     <= '0;
            discard_q <= '0;
            serr_q    <= 1'b0;
        end else if (clk_en) begin
            rsp_q     <= rsp_d;
            discard_q <= discard_d;
            serr_q    <= serr_d;
        end
    end

    // outputs
    assign cfg_rsp         = rsp_q;
    assign discard         = discard_q;
    assign discard_serr    = serr_q;
    assign discard_serr_en = serr_en_q;
    assign pri_short_timer = pri_short_q;
    assign sec_short_timer = sec_short_q;

endmodule : bridge_config_header_tail

// file: bridge_tail_properties.sv
module bridge_tail_properties
    import bridge_tail_pkg::*;
(
    input wire logic  core_clk,
    input wire logic  reset,
    input wire logic  clk_en,
    input cfg_req_type cfg_req,
    input cfg_rsp_type cfg_rsp,
    input discard_type discard,
    input wire logic  discard_serr,
    input wire logic  discard_serr_en
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // accepted requests and their dword
    wire       take = cfg_req.valid && clk_en;
    wire       rd   = take && !cfg_req.write;
    wire [5:0] dw   = cfg_req.addr[7:2];
    property p_ack; take |=> cfg_rsp.ack; endproperty
    a_ack: assert property (p_ack) else $error("answer late");
    property p_miss; take && (dw < 6'h0D) |=> cfg_rsp.ack && !cfg_rsp.hit && cfg_rsp.rdata == 0; endproperty
    a_miss: assert property (p_miss) else $error("miss answered wrong");
    property p_cap; rd && dw == 6'h0D |=> cfg_rsp.hit && cfg_rsp.rdata == 32'h000000DC; endproperty
    a_cap: assert property (p_cap) else $error("list head wrong");
    property p_rom; rd && dw == 6'h0E |=> cfg_rsp.hit && cfg_rsp.rdata == 32'h0; endproperty
    a_rom: assert property (p_rom) else $error("rom window not zero");
    property p_fixed; cfg_rsp.ack |-> cfg_rsp.rdata[31:28] == 4'h0 && cfg_rsp.rdata[23:8] == 16'h0; endproperty
    a_fixed: assert property (p_fixed) else $error("fixed bits not zero");
    property p_serr; discard_serr |-> discard.primary && discard_serr_en; endproperty
    a_serr: assert property (p_serr) else $error("serr without cause");
    property p_pulse; discard.secondary && clk_en |=> !discard.secondary; endproperty
    a_pulse: assert property (p_pulse) else $error("discard not a pulse");
    property p_freeze; !clk_en |=> $stable(cfg_rsp) && $stable(discard); endproperty
    a_freeze: assert property (p_freeze) else $error("moved while frozen");
endmodule : bridge_tail_properties

bind bridge_config_header_tail bridge_tail_properties u_bridge_tail_properties (
    .core_clk(core_clk), .reset(reset), .clk_en(clk_en), .cfg_req(cfg_req),
    .cfg_rsp(cfg_rsp), .discard(discard), .discard_serr(discard_serr),
    .discard_serr_en(discard_serr_en));

// file: cfg_host.sv
module cfg_host
    import bridge_tail_pkg::*;
(
    input wire logic  core_clk,
    output cfg_req_type req
);
    timeunit 1ns;
    timeprecision 1ps;
    // one strobe per call, valid stays up across back-to-back calls
    task automatic send(input logic w, input logic [7:0] a, input logic [3:0] be,
                        input logic [31:0] v);
        @(negedge core_clk);
        req = {1'b1, w, a, be, v};
    endtask : send
    // released bus shows inverted leftovers, not the last value
    task automatic idle();
        @(negedge core_clk);
        req = {1'b0, ~req.write, ~req.addr, ~req.byte_en, ~req.wdata};
    endtask : idle
    initial req = '0;
endmodule : cfg_host

// file: testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import bridge_tail_pkg::*;
    localparam int LONG  = 16;
    localparam int SHORT = 4;
    logic        core_clk = 0, reset = 1, clk_en = 1;
    logic        pri_pend = 0, pri_rep = 0, sec_pend = 0, sec_rep = 0;
    logic        serr, serr_en, pri_short, sec_short;
    cfg_req_type cfg_req;
    cfg_rsp_type cfg_rsp;
    discard_type discard;
    logic [32:0] exp_q[$];
    logic [7:0]  addrs[7] = '{8'h34, 8'h38, 8'h3C, 8'h3E, 8'h30, 8'h40, 8'hFC};
    logic [7:0]  note_m = 8'hFF;
    logic [3:0]  ctl_m = 4'h0;
    logic [31:0] r, d;
    int          n_errors = 0, tests_run = 0, seed = 77677, k;
    logic        en_seen = 0;

    cfg_host u_cfg_host (.core_clk(core_clk), .req(cfg_req));
    bridge_config_header_tail #(.LONG_CYCLES(LONG), .SHORT_CYCLES(SHORT))
        u_bridge_config_header_tail (
        .core_clk(core_clk), .reset(reset), .clk_en(clk_en), .cfg_req(cfg_req),
        .cfg_rsp(cfg_rsp), .pri_delayed_pending(pri_pend), .pri_delayed_repeat(pri_rep),
        .sec_delayed_pending(sec_pend), .sec_delayed_repeat(sec_rep), .discard(discard),
        .discard_serr(serr), .discard_serr_en(serr_en), .pri_short_timer(pri_short),
        .sec_short_timer(sec_short));

    initial forever #2.5 core_clk = ~core_clk;

    task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic end_sim();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    task automatic guard(input int c);
        if (c >= 100) begin
            n_errors++;
            end_sim();
        end
    endtask : guard
    // note the answer, update the register model, then hand it to the host
    task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] be,
                       input logic [31:0] v);
        exp_q.push_back({a[7:2] inside {6'h0D, 6'h0E, 6'h0F}, (w || a[7:2] != 6'h0F) ?
            (!w && a[7:2] == 6'h0D ? 32'hDC : 32'h0) : {4'h0, ctl_m, 16'h0, note_m}});
        if (w && a[7:2] == 6'h0F && be[0]) note_m = v[7:0];
        if (w && a[7:2] == 6'h0F && be[3]) ctl_m = {v[27], ctl_m[2] & ~v[26], v[25:24]};
        u_cfg_host.send(w, a, be, v);
    endtask : acc
    // hold one side's delayed request, optionally repeated once, until discarded
    task automatic tmr(input logic sec, input int n, input logic rep);
        k = 0;
        {sec_pend, pri_pend} = {sec, !sec};
        while (discard !== {!sec, sec} && k < 100) begin
            @(negedge core_clk);
            k++;
            {sec_rep, pri_rep} = (rep && k == 2) ? {sec, !sec} : 2'b00;
        end
        guard(k);
        check("discard_len", k, n);
        check("discard_serr", serr, ctl_m[3] & !sec);
        {sec_pend, pri_pend} = 2'b00;
        ctl_m[2] = 1'b1;
    endtask : tmr

    // main sequence
    initial begin
        repeat (10) @(negedge core_clk);
        reset = 0;
        foreach (addrs[i]) acc(0, addrs[i], 4'hF, 32'h0);
        repeat (16) begin
            r = $random(seed);
            d = $random(seed);
            acc(1, addrs[r[2:0] % 7], r[7:4], d);
            acc(0, addrs[r[2:0] % 7], 4'hF, 32'h0);
            u_cfg_host.idle();
            check("ctl_out", {serr_en, sec_short, pri_short}, {ctl_m[3], ctl_m[1:0]});
        end
        for (int i = 0; i < 4; i++) begin
            acc(1, 8'h3E, 4'h8, {4'h0, i[1], 1'b1, i[1], i[1], 24'h0});
            acc(0, 8'h3C, 4'hF, 32'h0);
            u_cfg_host.idle();
            tmr(i[0], (i[1] ? SHORT : LONG) + ((i == 3) ? 4 : 1), i == 3);
            acc(1, 8'h3C, 4'h8, 32'h0);
            acc(0, 8'h3C, 4'hF, 32'h0);
            u_cfg_host.idle();
        end
        acc(0, 8'h3C, 4'hF, 32'h0);
        u_cfg_host.idle();
        clk_en = 0;
        repeat (3) @(negedge core_clk);
        clk_en = 1;
        repeat (2) @(negedge core_clk);
        reset = 1;
        repeat (2) @(negedge core_clk);
        reset = 0;
        {note_m, ctl_m} = 12'hFF0;
        acc(0, 8'h3C, 4'hF, 32'h0);
        u_cfg_host.idle();
        k = 0;
        while (exp_q.size() != 0 && k < 100) begin
            @(negedge core_clk);
            k++;
        end
        guard(k);
        end_sim();
    end

    // remember whether the last rising edge could launch a fresh answer
    always @(posedge core_clk) en_seen <= clk_en && !reset;
    // each answer consumed once, half a cycle after launch, against the oldest note
    always @(negedge core_clk) begin
        if (en_seen && cfg_rsp.ack === 1'b1) begin
            check("cfg_rsp", {cfg_rsp.hit, cfg_rsp.rdata},
                  exp_q.size() ? exp_q.pop_front() : 33'bx);
        end
    end
endmodule : testbench
